/* File: design/i2c_data_buffer_defs.vh */
// Register offsets, field positions, reset values and codes for the data buffer block
`ifndef I2C_DATA_BUFFER_DEFS_VH
`define I2C_DATA_BUFFER_DEFS_VH

// Byte offsets on the register bus
`define OFF_CTRL 8'h00
`define OFF_DATA_OR_ADDR 8'h04
`define OFF_MODE_OR_ADDR2 8'h08
`define OFF_STATUS 8'h0C
`define OFF_IRQ_STATUS 8'h10
`define OFF_IRQ_MASK 8'h14

// Control register fields
`define CTRL_ENABLE 0
`define CTRL_TX_SEL 1
`define CTRL_MASTER 2

// Mode register fields
`define MODE_ORDER 7
`define MODE_BITS_HI 2
`define MODE_BITS_LO 0

// Status and interrupt bit positions
`define ST_TX_EMPTY 0
`define ST_RX_FULL 1
`define ST_ADDR_MATCH 2
`define ST_STOP 3

// Reset values
`define RST_CTRL 8'h00
`define RST_ADDR 8'h00
`define RST_MODE 8'h00
`define RST_DATA 8'h00
`define RST_IRQ 4'h0

// Format select codes {primary, secondary}
`define FMT_BOTH 2'b00
`define FMT_FIRST 2'b01
`define FMT_SECOND 2'b10
`define FMT_CLOCKED 2'b11

// Full frame length in data bits
`define FULL_FRAME 4'h8

`endif

/* File: design/i2c_data_buffer_and_own_address.v */
// Two-wire serial data path: shift register, holding buffers, own address, APB registers
//
// What this block does
// [RL1] One 8-bit data port built from shift register and two holding buffers.
// [RL2] Transmit: frame end with full transmit buffer copies it to shift register.
// [RL3] Receive: frame end with free receive buffer copies shift register into it.
// [RL4] Software justifies short transmit data to MSB or LSB by bit order.
// [RL5] Software reads short received data from LSB or MSB side by bit order.
// [RL6] Data port is reachable only while the interface is enabled.
// [RL7] Data port content after reset is not defined by the device.
// [RL8] Empty flag sets on own start, tx select, buffer copy, rx-to-tx switch.
// [RL9] Empty flag clears on data write, stops, and throughout receive mode.
// [RL10] Full flag sets on copy into receive buffer, clears on data read; the code clears it only on reads in receive mode.
// [RL11] Flag changes feed the interrupt status and the interrupt line.
// [RL12] Own address holds seven address bits and a format bit, reset zero.
// [RL13] Address registers are reachable only while the interface is disabled.
// [RL14] Format bits select both, first, second address or clocked serial.
// [RL15] Shift MSB first when bit order is zero, LSB first when one.
// [RL16] Address registers and data/mode registers share locations by enable.
// [RL17] Slave compares received address with fields chosen by the format.
// [RL18] Buffer copies happen in the same cycle as the frame end.
//
// Added by the designer: the APB interface to the registers and the address map.
`timescale 1ns/1ns
`default_nettype none
`include "i2c_data_buffer_defs.vh"

module i2c_data_buffer_and_own_address
(
    input wire ref_clk,
    input wire rst_n,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output wire [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire scl_in,
    input wire sda_in,
    output wire sda_out,
    output reg sda_oe,
    output wire irq
);

    // Synchronised bus lines and edge history
    reg scl_s1_ff, scl_s2_ff, scl_s3_ff;
    reg sda_s1_ff, sda_s2_ff, sda_s3_ff;
    reg [7:0] ctrl_ff, own_addr_ff, addr2_ff, mode_ff;
    reg [7:0] shift_ff, rx_buf_ff, tx_buf_ff;
    reg tx_empty_ff, rx_full_ff;
    reg [3:0] bit_cnt_ff;
    reg busy_ff, addr_frame_ff, matched_ff, fall_d_ff;
    reg [3:0] irq_st_ff, irq_mask_ff;
    reg tx_empty_d_ff, rx_full_d_ff;

    wire enable = ctrl_ff[`CTRL_ENABLE];
    wire tx_sel = ctrl_ff[`CTRL_TX_SEL];
    wire master = ctrl_ff[`CTRL_MASTER];
    wire lsb_first = mode_ff[`MODE_ORDER];
    wire [1:0] fmt = {own_addr_ff[0], addr2_ff[0]};
    wire clocked = (fmt == `FMT_CLOCKED);

    // Zero in the bit-count field means a full byte
    wire [3:0] data_bits = (mode_ff[`MODE_BITS_HI:`MODE_BITS_LO] == 3'h0) ? `FULL_FRAME :
        {1'b0, mode_ff[`MODE_BITS_HI:`MODE_BITS_LO]};
    wire [3:0] frame_len = clocked ? data_bits : data_bits + 4'h1;

    // Line events seen through the synchroniser
    wire scl_rise = scl_s2_ff & ~scl_s3_ff;
    wire scl_fall = ~scl_s2_ff & scl_s3_ff;
    wire start_det = scl_s2_ff & scl_s3_ff & ~sda_s2_ff & sda_s3_ff & ~clocked;
    wire stop_det = scl_s2_ff & scl_s3_ff & sda_s2_ff & ~sda_s3_ff & ~clocked;
    wire frame_end = busy_ff & scl_fall & (bit_cnt_ff == frame_len);
    wire ack_slot = ~clocked & (bit_cnt_ff == data_bits);

    // Address compare against the fields the format enables
    function addr_hit;
        input [1:0] f;
        input [6:0] rx;
        input [6:0] a1;
        input [6:0] a2;
        begin
            case (f)
                `FMT_BOTH: addr_hit = (rx == a1) | (rx == a2); // [RL14]
                `FMT_FIRST: addr_hit = (rx == a1); // [RL14]
                `FMT_SECOND: addr_hit = (rx == a2); // [RL14]
                default: addr_hit = 1'b0; // [RL14]
            endcase
        end
    endfunction

    wire rx_addr_ok = addr_hit(fmt, shift_ff[7:1], own_addr_ff[7:1], addr2_ff[7:1]); // [RL17]
    wire match_evt = frame_end & addr_frame_ff & ~master & rx_addr_ok;
    // Unaddressed slaves must not disturb the buffers
    wire active = master | clocked | matched_ff;
    // Address ack must use the live compare; the match flag only sets after the ack bit
    wire match_or_hold = rx_addr_ok & ~master; // [RL17]

    // APB decode; zero wait states
    wire acc = psel & penable;
    wire wr = acc & pwrite;
    wire rd = acc & ~pwrite;
    wire hit_ctrl = (paddr == `OFF_CTRL);
    wire hit_data = (paddr == `OFF_DATA_OR_ADDR);
    wire hit_mode = (paddr == `OFF_MODE_OR_ADDR2);
    wire hit_stat = (paddr == `OFF_STATUS);
    wire hit_ist = (paddr == `OFF_IRQ_STATUS);
    wire hit_imask = (paddr == `OFF_IRQ_MASK);
    wire mapped = hit_ctrl | hit_data | hit_mode | hit_stat | hit_ist | hit_imask;
    wire data_wr = wr & hit_data & enable; // [RL6] [RL16]
    wire data_rd = rd & hit_data & enable; // [RL6] [RL16]
    wire addr_wr = wr & hit_data & ~enable; // [RL13] [RL16]
    wire mode_wr = wr & hit_mode & enable; // [RL16]
    wire addr2_wr = wr & hit_mode & ~enable; // [RL13] [RL16]
    wire ctrl_wr = wr & hit_ctrl;
    wire tx_sel_rise = ctrl_wr & pwdata[`CTRL_TX_SEL] & ~tx_sel;

    assign pready = 1'b1;
    assign pslverr = psel & penable & ~mapped;

    reg [7:0] rdata;
    // Read mux; shared locations follow the enable bit
    always @*
    begin
        rdata = 8'h00;
        if (hit_ctrl)
            rdata = ctrl_ff;
        else if (hit_data)
            rdata = enable ? rx_buf_ff : own_addr_ff; // [RL16]
        else if (hit_mode)
            rdata = enable ? mode_ff : addr2_ff; // [RL16]
        else if (hit_stat)
            rdata = {4'h0, irq_st_ff[3] & 1'b0, matched_ff, rx_full_ff, tx_empty_ff};
        else if (hit_ist)
            rdata = {4'h0, irq_st_ff};
        else if (hit_imask)
            rdata = {4'h0, irq_mask_ff};
    end
    assign prdata = rd ? {24'h000000, rdata} : 32'h00000000;

    // Two-stage synchronisers plus one stage of edge history
    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            scl_s1_ff <= 1'b1;
            scl_s2_ff <= 1'b1;
            scl_s3_ff <= 1'b1;
            sda_s1_ff <= 1'b1;
            sda_s2_ff <= 1'b1;
            sda_s3_ff <= 1'b1;
        end
        else
        begin
            scl_s1_ff <= scl_in;
            scl_s2_ff <= scl_s1_ff;
            scl_s3_ff <= scl_s2_ff;
            sda_s1_ff <= sda_in;
            sda_s2_ff <= sda_s1_ff;
            sda_s3_ff <= sda_s2_ff;
        end
    end

    // Software registers; own address fields reset to zero
    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctrl_ff <= `RST_CTRL;
            own_addr_ff <= `RST_ADDR; // [RL12]
            addr2_ff <= `RST_ADDR; // [RL12]
            mode_ff <= `RST_MODE;
            irq_mask_ff <= `RST_IRQ;
        end
        else
        begin
            if (ctrl_wr)
                ctrl_ff <= {5'h00, pwdata[2:0]};
            if (addr_wr)
                own_addr_ff <= pwdata[7:0]; // [RL12]
            if (addr2_wr)
                addr2_ff <= pwdata[7:0];
            if (mode_wr)
                mode_ff <= pwdata[7:0];
            if (wr & hit_imask)
                irq_mask_ff <= pwdata[3:0];
        end
    end

    // Frame tracking: bit count, address phase and match state
    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            bit_cnt_ff <= 4'h0;
            busy_ff <= 1'b0;
            addr_frame_ff <= 1'b0;
            matched_ff <= 1'b0;
        end
        else if (start_det)
        begin
            bit_cnt_ff <= 4'h0;
            busy_ff <= 1'b1;
            addr_frame_ff <= 1'b1;
            matched_ff <= 1'b0;
        end
        else if (stop_det)
        begin
            busy_ff <= 1'b0;
            matched_ff <= 1'b0;
        end
        else
        begin
            // Clocked format has no start, so any clock marks activity
            if (clocked & scl_fall)
                busy_ff <= 1'b1;
            if (frame_end)
            begin
                bit_cnt_ff <= 4'h0;
                addr_frame_ff <= 1'b0;
            end
            else if (scl_rise)
                bit_cnt_ff <= bit_cnt_ff + 4'h1;
            if (match_evt)
                matched_ff <= 1'b1; // [RL17]
        end
    end

    // Shift register and holding buffers move together with the flags
    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            shift_ff <= `RST_DATA; // [RL7]
            rx_buf_ff <= `RST_DATA; // [RL7]
            tx_buf_ff <= `RST_DATA; // [RL7]
            tx_empty_ff <= 1'b0;
            rx_full_ff <= 1'b0;
        end
        else
        begin
            if (data_wr)
                tx_buf_ff <= pwdata[7:0]; // [RL1]
            // Data bits shift on the rising clock; the ack bit does not
            if (scl_rise & ~ack_slot & (bit_cnt_ff < data_bits))
                shift_ff <= lsb_first ? {sda_s2_ff, shift_ff[7:1]} :
                    {shift_ff[6:0], sda_s2_ff}; // [RL15]
            // Transmit copy at frame end, or at our own start
            if (tx_sel & ~tx_empty_ff & active & (frame_end | (start_det & master)))
                shift_ff <= tx_buf_ff; // [RL2] [RL18]
            // Receive copy only into a free buffer
            if (~tx_sel & ~rx_full_ff & active & frame_end)
                rx_buf_ff <= shift_ff; // [RL3] [RL18]

            // Empty flag; sets win over clears within transmit mode
            if (~tx_sel & ~tx_sel_rise)
                tx_empty_ff <= 1'b0; // [RL9]
            else if ((start_det & master & tx_sel) // [RL8]
                || (tx_sel_rise & clocked) // [RL8]
                || (tx_sel & ~tx_empty_ff & active & frame_end) // [RL8] [RL18]
                || (tx_sel_rise & busy_ff)) // [RL8]
                tx_empty_ff <= 1'b1;
            else if (data_wr | (stop_det & master) | stop_det)
                tx_empty_ff <= 1'b0; // [RL9]

            // Full flag; a copy in the read cycle keeps it set
            if (~tx_sel & ~rx_full_ff & active & frame_end)
                rx_full_ff <= 1'b1; // [RL10]
            else if (data_rd & ~tx_sel)
                rx_full_ff <= 1'b0; // [RL10]
        end
    end

    // Drive data one cycle after the clock falls so a fresh load is seen
    assign sda_out = 1'b0;
    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            fall_d_ff <= 1'b0;
            sda_oe <= 1'b0;
        end
        else
        begin
            fall_d_ff <= scl_fall;
            if (start_det | stop_det)
                sda_oe <= 1'b0;
            else if (fall_d_ff)
            begin
                if (ack_slot)
                    sda_oe <= ~tx_sel & (active | (addr_frame_ff & match_or_hold));
                else if (tx_sel & active & ~addr_frame_ff | tx_sel & master)
                    sda_oe <= lsb_first ? ~shift_ff[0] : ~shift_ff[7]; // [RL15]
                else
                    sda_oe <= 1'b0;
            end
        end
    end
    // Sticky interrupt status; set wins over write-one-to-clear
    wire [3:0] irq_set = {stop_det, match_evt, rx_full_ff & ~rx_full_d_ff,
        tx_empty_ff & ~tx_empty_d_ff};
    wire [3:0] irq_clr = (wr & hit_ist) ? pwdata[3:0] : 4'h0;
    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            irq_st_ff <= `RST_IRQ;
            tx_empty_d_ff <= 1'b0;
            rx_full_d_ff <= 1'b0;
        end
        else
        begin
            tx_empty_d_ff <= tx_empty_ff;
            rx_full_d_ff <= rx_full_ff;
            irq_st_ff <= (irq_st_ff & ~irq_clr) | irq_set; // [RL11]
        end
    end
    assign irq = |(irq_st_ff & irq_mask_ff); // [RL11]

endmodule

`default_nettype wire

/* File: tb/i2c_bus_master_model.sv */
// Two-wire bus master model driving the clock and data lines
`timescale 1ns/1ns
`default_nettype none
module i2c_bus_master_model (
    input wire logic ref_clk,
    input wire logic dut_oe,
    output logic scl,
    output wire logic sda,
    output logic acked
);
    logic drv_low = 1'b0;
    // Open drain with pull-up: a released line reads high
    assign sda = !(drv_low || dut_oe);
    initial
    begin
        scl = 1'b1;
        acked = 1'b0;
    end
    // Half of the 800 ns link clock; clock stands low between frames and high after a stop
    task automatic half();
        repeat (4) @(posedge ref_clk);
    endtask
    task automatic start();
        drv_low <= 1'b1;
        half();
        scl <= 1'b0;
        half();
    endtask
    // Data changes only while the clock is low, most significant bit first
    task automatic send(input logic [7:0] b);
        for (int i = 7; i >= 0; i--)
        begin
            drv_low <= !b[i];
            half();
            scl <= 1'b1;
            half();
            scl <= 1'b0;
        end
        drv_low <= 1'b0;
        half();
        scl <= 1'b1;
        repeat (2) @(posedge ref_clk);
        acked = !sda;
        repeat (2) @(posedge ref_clk);
        scl <= 1'b0;
        half();
    endtask
    task automatic stop();
        drv_low <= 1'b1;
        half();
        scl <= 1'b1;
        half();
        drv_low <= 1'b0;
        half();
    endtask
endmodule
`default_nettype wire

/* File: tb/i2c_buffer_properties.sv */
// Concurrent checks on the data buffer block's register and line ports
`timescale 1ns/1ns
`default_nettype none
module i2c_buffer_properties (
    input wire ref_clk,
    input wire rst_n,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire sda_out,
    input wire irq
);
    logic en_ff;
    logic [7:0] addr_ff;
    logic [3:0] mask_ff;
    wire wr = psel && penable && pwrite;
    wire rd = psel && penable && !pwrite;
    wire mapped = paddr inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14};
    // Shadows so that reads can be tied back to earlier writes
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            en_ff <= 1'b0;
            addr_ff <= 8'h00;
            mask_ff <= 4'h0;
        end
        else if (wr)
        begin
            if (paddr == 8'h00)
                en_ff <= pwdata[0];
            if (paddr == 8'h04 && !en_ff)
                addr_ff <= pwdata[7:0];
            if (paddr == 8'h14)
                mask_ff <= pwdata[3:0];
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    sequence s_access;
        psel && penable;
    endsequence
    a_zero_wait: assert property (s_access |-> pready)
        else $error("pready low in access phase");
    a_idle_rdata: assert property (!rd |-> prdata == 32'h0)
        else $error("read data outside a read access");
    a_unmapped_err: assert property (s_access ##0 !mapped |-> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    a_mapped_ok: assert property (s_access ##0 mapped |-> !pslverr)
        else $error("mapped access refused");
    a_upper_zero: assert property (rd |-> prdata[31:8] == 24'h0)
        else $error("upper read bits not zero");
    a_addr_readback: assert property (rd && paddr == 8'h04 && !en_ff |-> prdata[7:0] == addr_ff)
        else $error("own address read back wrong");
    a_irq_level: assert property (rd && paddr == 8'h10 |-> irq == |(prdata[3:0] & mask_ff))
        else $error("interrupt line disagrees with status");
    a_sda_low: assert property (sda_out == 1'b0)
        else $error("data line driven high");
endmodule
bind i2c_data_buffer_and_own_address i2c_buffer_properties i2c_buffer_properties_i (
    .ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sda_out(sda_out), .irq(irq));
`default_nettype wire

/* File: tb/tb_i2c_data_buffer_and_own_address.sv */
// Self-checking bench for the two-wire data buffer block
`timescale 1ns/1ns
`default_nettype none
module tb_i2c_data_buffer_and_own_address;
    logic ref_clk;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    wire [31:0] prdata;
    wire pready, pslverr, scl, sda, sda_out, sda_oe, irq, acked;
    int n_fail = 0;
    int checked = 0;
    logic [31:0] rd;
    logic err;
    i2c_data_buffer_and_own_address i2c_data_buffer_and_own_address_i (
        .ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
        .sda_oe(sda_oe), .irq(irq));
    i2c_bus_master_model i2c_bus_master_model_i (
        .ref_clk(ref_clk), .dut_oe(sda_oe), .scl(scl), .sda(sda), .acked(acked));
    initial
    begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            n_fail++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Setup then access; the request is held until pready is seen high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        @(posedge ref_clk);
        while (pready !== 1'b1)
            @(posedge ref_clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic t_regs();
        apb(0, 8'h04, 0);
        chk(rd, 32'h0);
        apb(1, 8'h04, 32'hA4);
        apb(1, 8'h08, 32'h0);
        apb(0, 8'h04, 0);
        chk(rd, 32'hA4);
        apb(0, 8'h20, 0);
        chk(err, 1'b1);
        chk(rd, 32'h0);
        apb(1, 8'h00, 32'h1);
        apb(1, 8'h04, 32'h5A);
        apb(0, 8'h0C, 0);
        chk(rd[0], 1'b0);
        apb(1, 8'h00, 32'h0);
        apb(0, 8'h04, 0);
        chk(rd, 32'hA4);
        apb(1, 8'h00, 32'h1);
        $display("test regs done");
    endtask
    // Full buffer must not be overwritten by a later frame
    task automatic t_slave_rx();
        apb(1, 8'h14, 32'h2);
        i2c_bus_master_model_i.start();
        i2c_bus_master_model_i.send(8'hA4);
        chk(acked, 1'b1);
        apb(0, 8'h04, 0);
        apb(1, 8'h10, 32'hF);
        i2c_bus_master_model_i.send(8'h3C);
        apb(0, 8'h0C, 0);
        chk(rd[1:0], 2'b10);
        chk(irq, 1'b1);
        i2c_bus_master_model_i.send(8'h81);
        apb(0, 8'h04, 0);
        chk(rd, 32'h3C);
        apb(0, 8'h0C, 0);
        chk(rd[1], 1'b0);
        apb(1, 8'h10, 32'hF);
        // The clear lands at the access edge; look once it has settled
        @(posedge ref_clk);
        chk(irq, 1'b0);
        i2c_bus_master_model_i.stop();
        $display("test slave receive done");
    endtask
    task automatic t_unaddr();
        i2c_bus_master_model_i.start();
        i2c_bus_master_model_i.send(8'h66);
        chk(acked, 1'b0);
        i2c_bus_master_model_i.send(8'h11);
        apb(0, 8'h0C, 0);
        chk(rd[1], 1'b0);
        chk(irq, 1'b0);
        i2c_bus_master_model_i.stop();
        $display("test unaddressed done");
    endtask
    // Empty flag in clocked format: set by transmit select, cleared by data and receive mode
    task automatic t_tx_flags();
        apb(1, 8'h00, 32'h0);
        apb(1, 8'h04, 32'hA5);
        apb(1, 8'h08, 32'h01);
        apb(1, 8'h00, 32'h1);
        apb(1, 8'h10, 32'hF);
        apb(1, 8'h14, 32'h1);
        apb(1, 8'h00, 32'h3);
        apb(0, 8'h0C, 0);
        chk(rd[0], 1'b1);
        chk(irq, 1'b1);
        apb(1, 8'h00, 32'h1);
        apb(0, 8'h0C, 0);
        chk(rd[0], 1'b0);
        apb(1, 8'h00, 32'h3);
        apb(0, 8'h0C, 0);
        chk(rd[0], 1'b1);
        apb(1, 8'h04, 32'h96);
        apb(0, 8'h0C, 0);
        chk(rd[0], 1'b0);
        $display("test transmit flags done");
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (4) @(posedge ref_clk);
        rst_n <= 1'b1;
        t_regs();
        t_slave_rx();
        t_unaddr();
        t_tx_flags();
        end_sim();
    end
    // Whole run is about 520 cycles; cut a hang well beyond that
    initial
    begin
        #1000000;
        n_fail++;
        end_sim();
    end
endmodule
`default_nettype wire
